/* File: core/dbgcfg_pkg.sv */
// Constants of the debug bridge configuration and power control block
package dbgcfg_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int ADR_W = 12;
  localparam logic [11:0] CFG_OFFSET = 12'h120;
  localparam logic [11:0] STATUS_OFFSET = 12'h124;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [4:0] CFG_UNUSED_READ = 5'h1F;
  localparam int FUSE_POS = 0;
  localparam int LOW_POWER_CLOCK_N_POS = 1;
  localparam int EOFF_POS = 2;
  localparam int ST_SLEEP_POS = 0;
  localparam int ST_ENUM_POS = 1;
  localparam int ST_DTR_POS = 2;
  localparam int ST_SUP5_POS = 3;
  localparam int ST_PROG_POS = 4;
  localparam int CLK_3V3_HZ = 8_000_000;
  localparam int CLK_5V0_HZ = 16_000_000;
  localparam int CLK_LOW_POWER_CLOCK_N_HZ = 1_000_000;
  localparam logic [31:0] STEP_3V3 =
    32'((64'(CLK_3V3_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [31:0] STEP_5V0 =
    32'((64'(CLK_5V0_HZ) << 32) / 64'(CLK_HZ));
  localparam logic [31:0] STEP_LOW_POWER_CLOCK_N =
    32'((64'(CLK_LOW_POWER_CLOCK_N_HZ) << 32) / 64'(CLK_HZ));
  localparam int EOFF_TIMEOUT_S = 5;
  localparam int LED_POWERUP_MS = 100;
  localparam int LED_FLASH_MS = 50;
  localparam logic [31:0] EOFF_TIMEOUT_CYC =
    32'(64'(EOFF_TIMEOUT_S) * 64'(CLK_HZ));
  localparam logic [31:0] LED_POWERUP_CYC =
    32'(64'(LED_POWERUP_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [31:0] LED_FLASH_CYC =
    32'(64'(LED_FLASH_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [15:0] FUSE_PROT_MASK_DEF = 16'h000F;
  localparam int SYNC_N = 5;
endpackage : dbgcfg_pkg

/* File: core/dbgcfg_power_ctrl.sv */
// Debug bridge configuration register and power mode control
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
module dbgcfg_power_ctrl #(
  parameter logic [31:0] EOFF_TIMEOUT = dbgcfg_pkg::EOFF_TIMEOUT_CYC,
  parameter logic [31:0] LED_POWERUP = dbgcfg_pkg::LED_POWERUP_CYC,
  parameter logic [31:0] LED_FLASH = dbgcfg_pkg::LED_FLASH_CYC,
  parameter logic [15:0] FUSE_PROT_MASK = dbgcfg_pkg::FUSE_PROT_MASK_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [dbgcfg_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic usb_enumerated_i,
  input wire logic supply_5v_i,
  input wire logic host_dtr_i,
  input wire logic serial_tx_i,
  output logic serial_rx_o,
  output logic uart_txd_o,
  output logic uart_txd_oe_o,
  input wire logic uart_rxd_i,
  output logic uart_rxd_oe_o,
  input wire logic prog_active_i,
  input wire logic prog_tx_i,
  input wire logic prog_drive_i,
  output logic prog_rx_o,
  output logic single_wire_prog_link_o,
  output logic single_wire_prog_link_oe_o,
  input wire logic single_wire_prog_link_i,
  input wire logic fuse_wr_req_i,
  input wire logic [3:0] fuse_idx_i,
  output logic fuse_wr_grant_o,
  output logic fuse_wr_refuse_o,
  output logic prog_iface_en_o,
  output logic serial_iface_en_o,
  output logic low_power_clock_n,
  output logic deep_sleep_o,
  output logic clk_out_o,
  output logic status_led_o
);
  import dbgcfg_pkg::*;

  logic [7:0] feature_config_reg;
  logic [SYNC_N-1:0] async_in, s1, s2, s3, stable;
  logic dtr, enumerated, sup5, uart_rx, link_in;
  logic deep_sleep, timeout_done;
  logic [31:0] boot_cnt, led_cnt, nco_acc, next_step;
  logic led_boot, led_phase;
  logic eoff_mode, serial_en, prog_en, wr_cfg, hit_cfg, hit_status;
  logic [7:0] status_word;

  // Pins are filtered: a change counts once stages two and three agree
  assign async_in = {single_wire_prog_link_i, uart_rxd_i, supply_5v_i,
                     usb_enumerated_i, host_dtr_i};
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          stable[g] <= 1'b0;
        end else begin
          s1[g] <= async_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            stable[g] <= s3[g];
          end
        end
      end
    end
  endgenerate
  assign dtr = stable[0];
  assign enumerated = stable[1];
  assign sup5 = stable[2];
  assign uart_rx = stable[3];
  assign link_in = stable[4];

  // Bus decode, single-cycle ack, unmapped reads return zero
  assign hit_cfg = adr_i[ADR_W-1:2] == CFG_OFFSET[ADR_W-1:2];
  assign hit_status = adr_i[ADR_W-1:2] == STATUS_OFFSET[ADR_W-1:2];
  assign wr_cfg = cyc_i && stb_i && !ack_o && we_i && sel_i[0] && hit_cfg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o && !we_i) begin
        if (hit_cfg) begin
          dat_o <= {24'h000000, feature_config_reg};
        end else if (hit_status) begin
          dat_o <= {24'h000000, status_word};
        end else begin
          dat_o <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feature_config_reg <= CFG_RESET;
    end else if (wr_cfg) begin
      // Upper bits stay at one whatever is written
      feature_config_reg <= {CFG_UNUSED_READ, dat_i[2:0]};
    end
  end

  assign status_word = {3'h0, prog_en, sup5, dtr, enumerated, deep_sleep};

  // Extended-off: bit low means the mode is selected
  assign eoff_mode = !feature_config_reg[EOFF_POS];
  assign low_power_clock_n = feature_config_reg[LOW_POWER_CLOCK_N_POS];

  // Timer only runs once; later enumeration cannot wake the bridge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_cnt <= 32'h00000000;
    end else if (!timeout_done) begin
      boot_cnt <= boot_cnt + 32'h00000001;
    end
  end
  assign timeout_done = boot_cnt >= EOFF_TIMEOUT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_sleep <= 1'b0;
    end else if (eoff_mode && !enumerated && timeout_done) begin
      deep_sleep <= 1'b1;
    end
  end
  assign deep_sleep_o = deep_sleep;

  assign serial_en = !eoff_mode && !deep_sleep;
  assign prog_en = serial_en && low_power_clock_n;
  assign prog_iface_en_o = prog_en;
  assign serial_iface_en_o = serial_en;

  // Target UART pins, released to high impedance without DTR
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uart_txd_o <= 1'b1;
      uart_txd_oe_o <= 1'b0;
      uart_rxd_oe_o <= 1'b0;
      serial_rx_o <= 1'b1;
    end else begin
      uart_txd_o <= serial_tx_i;
      uart_txd_oe_o <= serial_en && dtr;
      uart_rxd_oe_o <= 1'b0;
      serial_rx_o <= (serial_en && dtr) ? uart_rx : 1'b1;
    end
  end

  // Single-wire link, cut off whenever programming is unusable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      single_wire_prog_link_o <= 1'b1;
      single_wire_prog_link_oe_o <= 1'b0;
      prog_rx_o <= 1'b1;
    end else begin
      single_wire_prog_link_o <= prog_tx_i;
      single_wire_prog_link_oe_o <= prog_en && prog_drive_i;
      prog_rx_o <= prog_en ? link_in : 1'b1;
    end
  end

  // Fuse filter: protected set is a mask over the fuse index
  assign fuse_wr_refuse_o = fuse_wr_req_i && (!prog_en ||
    (feature_config_reg[FUSE_POS] && FUSE_PROT_MASK[fuse_idx_i]));
  assign fuse_wr_grant_o = fuse_wr_req_i && !fuse_wr_refuse_o;

  // Clock output from a phase accumulator; edges jitter by one clk_i
  always_comb begin
    if (!low_power_clock_n) begin
      next_step = STEP_LOW_POWER_CLOCK_N;
    end else if (sup5) begin
      next_step = STEP_5V0;
    end else begin
      next_step = STEP_3V3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nco_acc <= 32'h00000000;
      clk_out_o <= 1'b0;
    end else begin
      nco_acc <= nco_acc + next_step;
      clk_out_o <= serial_en && nco_acc[31];
    end
  end

  // Status LED: brief power-up flash, then activity blink only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_cnt <= 32'h00000000;
      led_boot <= 1'b1;
      led_phase <= 1'b0;
    end else if (led_boot) begin
      led_cnt <= led_cnt + 32'h00000001;
      if (led_cnt >= LED_POWERUP - 32'h00000001) begin
        led_boot <= 1'b0;
        led_cnt <= 32'h00000000;
      end
    end else if (prog_active_i && prog_en) begin
      if (led_cnt >= LED_FLASH - 32'h00000001) begin
        led_cnt <= 32'h00000000;
        led_phase <= !led_phase;
      end else begin
        led_cnt <= led_cnt + 32'h00000001;
      end
    end else begin
      led_cnt <= 32'h00000000;
      led_phase <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_led_o <= 1'b1;
    end else begin
      status_led_o <= led_boot || led_phase;
    end
  end

  // Checks
  property p_cfg_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_cfg |=> feature_config_reg == {5'h1F, $past(dat_i[2:0])};
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not stored");

  property p_unused_ones;
    @(posedge clk_i) disable iff (rst_i)
    feature_config_reg[7:3] == 5'h1F;
  endproperty
  a_unused_ones: assert property (p_unused_ones)
    else $error("unused config bits not one");

  property p_uart_hiz;
    @(posedge clk_i) disable iff (rst_i)
    !dtr [*2] |-> !uart_txd_oe_o;
  endproperty
  a_uart_hiz: assert property (p_uart_hiz)
    else $error("uart driven without dtr");

  property p_sleep_cause;
    @(posedge clk_i) disable iff (rst_i)
    $rose(deep_sleep) |-> $past(eoff_mode) && $past(timeout_done)
      && !$past(enumerated);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause)
    else $error("deep sleep without cause");

  property p_eoff_off;
    @(posedge clk_i) disable iff (rst_i)
    eoff_mode [*2] |-> !clk_out_o && !serial_iface_en_o && !prog_iface_en_o;
  endproperty
  a_eoff_off: assert property (p_eoff_off)
    else $error("extended-off left a function on");

  property p_low_power_clock_n_prog;
    @(posedge clk_i) disable iff (rst_i)
    !low_power_clock_n |-> !prog_en && (serial_en == (!eoff_mode &&
      !deep_sleep));
  endproperty
  a_low_power_clock_n_prog: assert property (p_low_power_clock_n_prog)
    else $error("low power mode programming state wrong");

  property p_low_power_clock_n_step;
    @(posedge clk_i) disable iff (rst_i)
    !low_power_clock_n |-> next_step == STEP_LOW_POWER_CLOCK_N;
  endproperty
  a_low_power_clock_n_step: assert property (p_low_power_clock_n_step)
    else $error("low power clock step wrong");

  property p_fuse_prot;
    @(posedge clk_i) disable iff (rst_i)
    fuse_wr_req_i && feature_config_reg[0] && FUSE_PROT_MASK[fuse_idx_i]
      |-> fuse_wr_refuse_o && !fuse_wr_grant_o;
  endproperty
  a_fuse_prot: assert property (p_fuse_prot)
    else $error("protected fuse write granted");

  property p_fuse_open;
    @(posedge clk_i) disable iff (rst_i)
    fuse_wr_req_i && !feature_config_reg[0] && prog_en |-> fuse_wr_grant_o;
  endproperty
  a_fuse_open: assert property (p_fuse_open)
    else $error("fuse write refused with filter off");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held two cycles");

  c_sleep: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(deep_sleep));
  c_cfg_wr: cover property (@(posedge clk_i) disable iff (rst_i) wr_cfg);
  c_refuse: cover property (@(posedge clk_i) disable iff (rst_i)
    fuse_wr_refuse_o);
  c_uart_on: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(uart_txd_oe_o));
endmodule : dbgcfg_power_ctrl

/* File: dv/dbgcfg_target_model.sv */
// Target side model: UART loopback and pulled-up programming wire
`timescale 1ns/10ps
module dbgcfg_target_model (
  input wire logic uart_txd_i,
  input wire logic uart_txd_oe_i,
  input wire logic link_o_i,
  input wire logic link_oe_i,
  output logic uart_rxd_o,
  output logic link_i_o
);
  // Loops back at the host's settings; idles high when released
  assign uart_rxd_o = uart_txd_oe_i ? uart_txd_i : 1'b1;
  // Pull-up wins once the bridge lets go of the wire
  assign link_i_o = link_oe_i ? link_o_i : 1'b1;
endmodule : dbgcfg_target_model

/* File: dv/tb_top.sv */
// Self-checking bench for the configuration and power control block
`timescale 1ns/10ps
module tb_top;
  import dbgcfg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [11:0] adr_i = 12'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic [3:0] sel_i = 4'h0, fuse_idx_i = 4'h0;
  logic usb_enumerated_i = 1'b0, supply_5v_i = 1'b1, host_dtr_i = 1'b0;
  logic serial_tx_i = 1'b1, prog_active_i = 1'b0, prog_tx_i = 1'b1;
  logic prog_drive_i = 1'b0, fuse_wr_req_i = 1'b0;
  logic ack_o, serial_rx_o, uart_txd_o, uart_txd_oe_o, uart_rxd_i;
  logic prog_rx_o, single_wire_prog_link_o, single_wire_prog_link_oe_o;
  logic single_wire_prog_link_i, fuse_wr_grant_o, fuse_wr_refuse_o;
  logic prog_iface_en_o, serial_iface_en_o, low_power_clock_n;
  logic deep_sleep_o, clk_out_o, status_led_o, uart_rxd_oe_o;
  int bad_count = 0, checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  // Short counts keep the run brief
  dbgcfg_power_ctrl #(.EOFF_TIMEOUT(32'd200), .LED_POWERUP(32'd20),
    .LED_FLASH(32'd4)) dbgcfg_power_ctrl_inst (.clk_i, .rst_i, .adr_i,
    .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
    .usb_enumerated_i, .supply_5v_i, .host_dtr_i, .serial_tx_i,
    .serial_rx_o, .uart_txd_o, .uart_txd_oe_o, .uart_rxd_i,
    .uart_rxd_oe_o, .prog_active_i, .prog_tx_i, .prog_drive_i, .prog_rx_o,
    .single_wire_prog_link_o, .single_wire_prog_link_oe_o,
    .single_wire_prog_link_i, .fuse_wr_req_i, .fuse_idx_i, .fuse_wr_grant_o,
    .fuse_wr_refuse_o, .prog_iface_en_o, .serial_iface_en_o,
    .low_power_clock_n, .deep_sleep_o, .clk_out_o, .status_led_o);
  dbgcfg_target_model dbgcfg_target_model_inst (.uart_txd_i(uart_txd_o),
    .uart_txd_oe_i(uart_txd_oe_o), .link_o_i(single_wire_prog_link_o),
    .link_oe_i(single_wire_prog_link_oe_o), .uart_rxd_o(uart_rxd_i),
    .link_i_o(single_wire_prog_link_i));
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    checks_done++;
    if (seen !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task do_reset;
    rst_i <= 1'b1;
    tick(6);
    rst_i <= 1'b0;
    tick(1);
  endtask : do_reset
  // Classic cycle; ack and read data taken at the same edge
  task wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    check("ack", ack_o, 1);
    if (ack_o !== 1'b1) report_and_stop();
  endtask : wb
  function automatic logic pick(input int k);
    case (k)
      0: return deep_sleep_o;
      1: return uart_txd_oe_o;
      2: return serial_rx_o;
      3: return prog_rx_o;
      default: return status_led_o;
    endcase
  endfunction : pick
  task wait_for(input string nm, input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(nm, pick(k), v);
    if (pick(k) !== v) report_and_stop();
  endtask : wait_for
  // Phase accumulator jitters, so one edge of slack either way
  task count_edges(input int e);
    int c;
    logic last;
    c = 0;
    last = clk_out_o;
    repeat (2000) begin
      @(posedge clk_i);
      if (clk_out_o === 1'b1 && last === 1'b0) c++;
      last = clk_out_o;
    end
    check("clk_out_edges", (c >= e - 1 && c <= e + 1), 1);
  endtask : count_edges
  task fuse_scan(input logic [15:0] m);
    fuse_wr_req_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      fuse_idx_i <= 4'(i);
      tick(1);
      check("refuse", fuse_wr_refuse_o, m[i]);
      check("grant", fuse_wr_grant_o, !m[i]);
    end
    fuse_wr_req_i <= 1'b0;
  endtask : fuse_scan
  initial begin
    do_reset();
    check("led_up", status_led_o, 1);
    check("enables", {prog_iface_en_o, serial_iface_en_o}, 2'b11);
    check("txd_oe", uart_txd_oe_o, 0);
    wb(CFG_OFFSET, 1'b0, 32'h0);
    check("cfg_reset", rdat, 32'hFF);
    wait_for("led_off", 4, 1'b0, 60);
    count_edges(160);
    supply_5v_i <= 1'b0;
    tick(10);
    count_edges(80);
    fuse_scan(FUSE_PROT_MASK_DEF);
    wb(CFG_OFFSET, 1'b1, 32'h06);
    fuse_scan(16'h0000);
    wb(CFG_OFFSET, 1'b0, 32'h0);
    check("cfg_unused", rdat, 32'hFE);
    wb(CFG_OFFSET, 1'b1, 32'hF5);
    check("low_power_clock_n_n", low_power_clock_n, 0);
    check("low_power_clock_n_en", {prog_iface_en_o, serial_iface_en_o}, 2'b01);
    fuse_scan(16'hFFFF);
    count_edges(10);
    wb(CFG_OFFSET, 1'b1, 32'hFF);
    check("low_power_clock_n_off", low_power_clock_n, 1);
    count_edges(80);
    wb(12'h200, 1'b1, 32'h0);
    wb(12'h200, 1'b0, 32'h0);
    check("unmapped", rdat, 32'h0);
    wb(CFG_OFFSET, 1'b0, 32'h0);
    check("cfg_kept", rdat, 32'hFF);
    host_dtr_i <= 1'b1;
    wait_for("txd_oe_on", 1, 1'b1, 20);
    check("rxd_oe", uart_rxd_oe_o, 0);
    // Status: programming on, 3.3V supply, DTR seen, not enumerated
    wb(STATUS_OFFSET, 1'b0, 32'h0);
    check("status_dtr", rdat, 32'h14);
    serial_tx_i <= 1'b0;
    wait_for("loopback", 2, 1'b0, 20);
    serial_tx_i <= 1'b1;
    prog_drive_i <= 1'b1;
    prog_tx_i <= 1'b0;
    wait_for("link_low", 3, 1'b0, 20);
    prog_drive_i <= 1'b0;
    prog_active_i <= 1'b1;
    wait_for("led_flash_on", 4, 1'b1, 30);
    wait_for("led_flash_off", 4, 1'b0, 30);
    prog_active_i <= 1'b0;
    wb(CFG_OFFSET, 1'b1, 32'hFB);
    check("eoff_en", {prog_iface_en_o, serial_iface_en_o}, 2'b00);
    count_edges(0);
    wait_for("sleep", 0, 1'b1, 300);
    wb(STATUS_OFFSET, 1'b0, 32'h0);
    check("status_sleep", rdat, 32'h05);
    usb_enumerated_i <= 1'b1;
    do_reset();
    check("sleep_clear", deep_sleep_o, 0);
    tick(10);
    wb(CFG_OFFSET, 1'b1, 32'hFB);
    tick(300);
    check("no_sleep", deep_sleep_o, 0);
    report_and_stop();
  end
endmodule : tb_top
